// File: pkg/pcr_regs.svh
// Timing and level constants for the power, charge and reset control block
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// System clock period
`define PCR_CLK_PERIOD_NS 20
// Low-frequency oscillator period, derived from the system clock
`define PCR_LF_PERIOD_US 500
// Reset pin filter window
`define PCR_RST_MIN_US 1500
`define PCR_RST_MAX_US 4000
// Low time the external reset driver should give the pin
`define PCR_RST_RECOMMEND_US 5000
// Length of a reset raised by a break character or the watchdog, in low-frequency ticks
`define PCR_SOFT_RESET_TICKS 4'h4
// Indicator pulse: on for one tick out of a period of ticks
`define PCR_LED_PERIOD_TICKS 4'hf
`define PCR_LED_ON_TICK 4'h0
// Analog comparator trip levels seen by this logic
`define PCR_TRICKLE_THRESH_MV 2900
`define PCR_RECHARGE_DROP_MV 150
`define PCR_POR_LOW_MV 1250
`define PCR_POR_HIGH_MV 1300
// Trickle charge current request, in microamps
`define PCR_TRICKLE_CURRENT_UA 16'h1194
// Crystal frequency selection assumed after reset: the highest one
`define PCR_XTAL_SEL_MAX 4'hf
// Data rate after a cold reset
`define PCR_DATA_RATE_COLD 16'h0000
// Bit positions of the synchronised pin inputs
`define PCR_IN_HI_EN 0
`define PCR_IN_LO_EN 1
`define PCR_IN_RST_N 2
`define PCR_IN_CHG 3
`define PCR_IN_BELOW_TRICKLE 4
`define PCR_IN_AT_FLOAT 5
`define PCR_IN_BELOW_RECHARGE 6
`define PCR_IN_CHG_DONE 7
`define PCR_IN_XTAL 8
`define PCR_IN_POR_LOW 9
`define PCR_IN_POR_HIGH 10
`define PCR_IN_COUNT 11
// Synchroniser idle values: only the reset pin idles high
`define PCR_IN_IDLE 11'h004

`endif

// File: pkg/pcr_pkg.sv
// Types shared by the power, charge and reset control block
package pcr_pkg;

	typedef enum logic [2:0] {
		CHG_OFF,
		CHG_TRICKLE,
		CHG_FAST_CC,
		CHG_FAST_CV,
		CHG_STANDBY
	} pcr_charge_state_type;

endpackage

// File: rtl/pcr_sync.sv
// Three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pcr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	if (WIDTH < 1) begin : g_bad_width
		$error("pcr_sync: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		logic s1_reg;
		logic s2_reg;
		logic s3_reg;
		logic out_reg;

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				s1_reg <= IDLE[i];
				s2_reg <= IDLE[i];
				s3_reg <= IDLE[i];
				out_reg <= IDLE[i];
			end else begin
				s1_reg <= din[i];
				s2_reg <= s1_reg;
				s3_reg <= s2_reg;
				if (s2_reg == s3_reg) begin
					out_reg <= s3_reg;
				end
			end
		end

		assign dout[i] = out_reg;
	end

endmodule

`default_nettype wire

// File: rtl/pcr_reset_filter.sv
// Reset pin filter counting low-frequency ticks while the pin stays low
`timescale 1ns/1ps
`default_nettype none

module pcr_reset_filter #(
	parameter int TICKS = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic lf_tick,
	input wire logic pin_low,
	output logic filtered_reset
);

	if (TICKS < 1 || TICKS > 15) begin : g_bad_ticks
		$error("pcr_reset_filter: TICKS must lie in 1..15");
	end

	localparam logic [3:0] TICKS_L = 4'(TICKS);

	logic [3:0] count_reg;
	logic filtered_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 4'h0;
		end else if (!pin_low) begin
			count_reg <= 4'h0;
		end else if (lf_tick && count_reg != TICKS_L) begin
			count_reg <= count_reg + 4'h1;
		end
	end

	// Asserts once the pin has been low for the whole window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			filtered_reg <= 1'b0;
		end else begin
			filtered_reg <= pin_low && count_reg == TICKS_L;
		end
	end

	assign filtered_reset = filtered_reg;

endmodule

`default_nettype wire

// File: rtl/pcr_power_control.sv
// Power, charger, indicator and reset control logic
`timescale 1ns/1ps
`default_nettype none
`include "pcr_regs.svh"

// What this block does
// - High pin drives HV linear and switcher
// - HV/LV enabled by pin, firmware or charger
// - Audio regulator: low pin or firmware only
// - HV/LV low power in sleep or reset
// - Audio low power without audio cells/reset
// - Enable pins active high, idle low
// - Firmware latch holds regulators after boot
// - Charger off when supply disconnected
// - Below 2.9V trickle at 4.5mA
// - Above 2.9V fast constant current
// - At float voltage switch to constant voltage
// - Standby stops; 150mV drop restarts fast
// - Charging lights pad 0, pulsed before firmware
// - Charger supply presence readable by firmware
// - Open-drain pads; pad 0 also charger
// - Reset from pin, POR, break, watchdog
// - Reset pin filtered, 1.5 to 4.0ms
// - POR asserts below 1.25V, releases above 1.30V
// - Reset: pins inputs, documented pulls applied
// - After reset assume maximum crystal frequency
// - Warm reset keeps rate and RAM
module pcr_power_control #(
	parameter int LF_DIV = `PCR_LF_PERIOD_US * 1000 / `PCR_CLK_PERIOD_NS,
	parameter int CUR_W = 16,
	parameter int DRATE_W = 16,
	parameter int XSEL_W = 4,
	parameter int GPIO_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic high_side_regulator_enable,
	input wire logic low_side_regulator_enable,
	input wire logic reset_pin_n,
	input wire logic charger_supply_input,
	input wire logic bat_below_trickle,
	input wire logic bat_at_float,
	input wire logic bat_below_recharge,
	input wire logic bat_charge_done,
	input wire logic crystal_input_present,
	input wire logic core_below_por_low,
	input wire logic core_above_por_high,
	input wire logic uart_break_detected,
	input wire logic watchdog_expired,
	input wire logic deep_sleep,
	input wire logic audio_cells_enabled,
	input wire logic firmware_running,
	input wire logic fw_latch_set,
	input wire logic fw_latch_clear,
	input wire logic fw_hv_enable,
	input wire logic fw_lv_enable,
	input wire logic fw_smps_enable,
	input wire logic fw_audio_enable,
	input wire logic fw_indicator_0,
	input wire logic fw_indicator_1,
	input wire logic [CUR_W-1:0] fast_charge_current_setting,
	input wire logic [XSEL_W-1:0] fw_crystal_sel,
	input wire logic fw_crystal_sel_write,
	input wire logic [DRATE_W-1:0] fw_data_rate,
	input wire logic fw_data_rate_write,
	input wire logic [GPIO_W-1:0] fw_gpio_pull_down,
	output logic hv_enable,
	output logic smps_enable,
	output logic lv_enable,
	output logic audio_enable,
	output logic hv_low_power,
	output logic lv_low_power,
	output logic smps_low_power,
	output logic audio_low_power,
	output logic high_side_enable_status,
	output logic charger_powered_status,
	output pcr_pkg::pcr_charge_state_type charge_state,
	output logic [CUR_W-1:0] charge_current_request,
	output logic charge_cv_regulate,
	output logic indicator_pad_0_out,
	output logic indicator_pad_0_oe,
	output logic indicator_pad_1_out,
	output logic indicator_pad_1_oe,
	output logic chip_reset,
	output logic reset_was_cold,
	output logic pins_force_input,
	output logic serial_rx_cts_pull_down,
	output logic serial_tx_rts_pull_up,
	output logic [GPIO_W-1:0] gpio_pull_down,
	output logic [XSEL_W-1:0] crystal_freq_sel,
	output logic osc_free_run,
	output logic [DRATE_W-1:0] data_rate,
	output logic ram_contents_valid
);

	localparam int FILTER_TICKS =
		(`PCR_RST_MIN_US + `PCR_LF_PERIOD_US - 1) / `PCR_LF_PERIOD_US + 1;

	if (LF_DIV < 2) begin : g_bad_div
		$error("pcr_power_control: LF_DIV must be at least 2");
	end
	if (FILTER_TICKS * `PCR_LF_PERIOD_US > `PCR_RST_MAX_US) begin : g_bad_filter
		$error("pcr_power_control: reset filter exceeds its window");
	end
	if (CUR_W < 16 || XSEL_W < 4 || DRATE_W < 16) begin : g_bad_width
		$error("pcr_power_control: field widths too narrow");
	end

	// Pin inputs into the clock domain
	logic [`PCR_IN_COUNT-1:0] pin_raw;
	logic [`PCR_IN_COUNT-1:0] pin_sync;

	assign pin_raw[`PCR_IN_HI_EN] = high_side_regulator_enable;
	assign pin_raw[`PCR_IN_LO_EN] = low_side_regulator_enable;
	assign pin_raw[`PCR_IN_RST_N] = reset_pin_n;
	assign pin_raw[`PCR_IN_CHG] = charger_supply_input;
	assign pin_raw[`PCR_IN_BELOW_TRICKLE] = bat_below_trickle;
	assign pin_raw[`PCR_IN_AT_FLOAT] = bat_at_float;
	assign pin_raw[`PCR_IN_BELOW_RECHARGE] = bat_below_recharge;
	assign pin_raw[`PCR_IN_CHG_DONE] = bat_charge_done;
	assign pin_raw[`PCR_IN_XTAL] = crystal_input_present;
	assign pin_raw[`PCR_IN_POR_LOW] = core_below_por_low;
	assign pin_raw[`PCR_IN_POR_HIGH] = core_above_por_high;

	pcr_sync #(
		.WIDTH(`PCR_IN_COUNT),
		.IDLE(`PCR_IN_IDLE)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(pin_raw),
		.dout(pin_sync)
	);

	logic hi_pin;
	logic lo_pin;
	logic chg_present;

	// Active high; undriven pins sit low on their pull-downs
	assign hi_pin = pin_sync[`PCR_IN_HI_EN];
	assign lo_pin = pin_sync[`PCR_IN_LO_EN];
	assign chg_present = pin_sync[`PCR_IN_CHG];

	// Low-frequency oscillator tick
	logic [31:0] lf_count_reg;
	logic lf_tick_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lf_count_reg <= 32'h0;
			lf_tick_reg <= 1'b0;
		end else if (lf_count_reg == 32'(LF_DIV - 1)) begin
			lf_count_reg <= 32'h0;
			lf_tick_reg <= 1'b1;
		end else begin
			lf_count_reg <= lf_count_reg + 32'h1;
			lf_tick_reg <= 1'b0;
		end
	end

	// Reset sources
	logic pin_reset;
	logic por_reg;
	logic [3:0] soft_reset_count_reg;
	logic chip_reset_reg;
	logic cold_reg;

	pcr_reset_filter #(
		.TICKS(FILTER_TICKS)
	) u_reset_filter (
		.clk(clk),
		.rst_n(rst_n),
		.lf_tick(lf_tick_reg),
		.pin_low(!pin_sync[`PCR_IN_RST_N]),
		.filtered_reset(pin_reset)
	);

	// Power-on reset with hysteresis between the two trip levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			por_reg <= 1'b1;
		end else if (pin_sync[`PCR_IN_POR_LOW]) begin
			por_reg <= 1'b1;
		end else if (pin_sync[`PCR_IN_POR_HIGH]) begin
			por_reg <= 1'b0;
		end
	end

	// Break and watchdog events stretched into a reset of fixed length
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_count_reg <= 4'h0;
		end else if (uart_break_detected || watchdog_expired) begin
			soft_reset_count_reg <= `PCR_SOFT_RESET_TICKS;
		end else if (lf_tick_reg && soft_reset_count_reg != 4'h0) begin
			soft_reset_count_reg <= soft_reset_count_reg - 4'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chip_reset_reg <= 1'b1;
		end else begin
			chip_reset_reg <= pin_reset || por_reg || uart_break_detected
				|| watchdog_expired || soft_reset_count_reg != 4'h0;
		end
	end

	// Cold reset is the power-on one; the others are warm
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cold_reg <= 1'b1;
		end else if (por_reg) begin
			cold_reg <= 1'b1;
		end else if (pin_reset || uart_break_detected || watchdog_expired) begin
			cold_reg <= 1'b0;
		end
	end

	// Firmware latch holding the regulators on after boot
	logic latch_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch_reg <= 1'b0;
		end else if (chip_reset_reg || fw_latch_clear) begin
			latch_reg <= 1'b0;
		end else if (fw_latch_set) begin
			latch_reg <= 1'b1;
		end
	end

	// Battery charger controller
	pcr_pkg::pcr_charge_state_type chg_state_reg;
	pcr_pkg::pcr_charge_state_type chg_state_next;

	always_comb begin
		chg_state_next = chg_state_reg;
		if (!chg_present) begin
			chg_state_next = pcr_pkg::CHG_OFF;
		end else begin
			unique case (chg_state_reg)
				pcr_pkg::CHG_OFF: begin
					chg_state_next = pin_sync[`PCR_IN_BELOW_TRICKLE]
						? pcr_pkg::CHG_TRICKLE : pcr_pkg::CHG_FAST_CC;
				end
				pcr_pkg::CHG_TRICKLE: begin
					if (!pin_sync[`PCR_IN_BELOW_TRICKLE]) begin
						chg_state_next = pcr_pkg::CHG_FAST_CC;
					end
				end
				pcr_pkg::CHG_FAST_CC: begin
					if (pin_sync[`PCR_IN_BELOW_TRICKLE]) begin
						chg_state_next = pcr_pkg::CHG_TRICKLE;
					end else if (pin_sync[`PCR_IN_AT_FLOAT]) begin
						chg_state_next = pcr_pkg::CHG_FAST_CV;
					end
				end
				pcr_pkg::CHG_FAST_CV: begin
					if (pin_sync[`PCR_IN_CHG_DONE]) begin
						chg_state_next = pcr_pkg::CHG_STANDBY;
					end
				end
				pcr_pkg::CHG_STANDBY: begin
					if (pin_sync[`PCR_IN_BELOW_RECHARGE]) begin
						chg_state_next = pcr_pkg::CHG_FAST_CC;
					end
				end
				default: begin
					chg_state_next = pcr_pkg::CHG_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			chg_state_reg <= pcr_pkg::CHG_OFF;
		end else if (lf_tick_reg) begin
			chg_state_reg <= chg_state_next;
		end
	end

	logic charging;

	assign charging = chg_state_reg != pcr_pkg::CHG_OFF
		&& chg_state_reg != pcr_pkg::CHG_STANDBY;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			charge_current_request <= '0;
			charge_cv_regulate <= 1'b0;
		end else begin
			charge_cv_regulate <= chg_state_reg == pcr_pkg::CHG_FAST_CV;
			unique case (chg_state_reg)
				pcr_pkg::CHG_TRICKLE: begin
					charge_current_request <= CUR_W'(`PCR_TRICKLE_CURRENT_UA);
				end
				pcr_pkg::CHG_FAST_CC, pcr_pkg::CHG_FAST_CV: begin
					charge_current_request <= fast_charge_current_setting;
				end
				default: begin
					charge_current_request <= '0;
				end
			endcase
		end
	end

	// Regulator enables
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hv_enable <= 1'b0;
			smps_enable <= 1'b0;
			lv_enable <= 1'b0;
			audio_enable <= 1'b0;
		end else begin
			hv_enable <= hi_pin || fw_hv_enable || charging || latch_reg;
			smps_enable <= hi_pin || fw_smps_enable || charging || latch_reg;
			lv_enable <= lo_pin || fw_lv_enable || charging || latch_reg;
			audio_enable <= lo_pin || fw_audio_enable || latch_reg;
		end
	end

	// Low-power modes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hv_low_power <= 1'b1;
			lv_low_power <= 1'b1;
			smps_low_power <= 1'b1;
			audio_low_power <= 1'b1;
		end else begin
			hv_low_power <= deep_sleep || chip_reset_reg;
			lv_low_power <= deep_sleep || chip_reset_reg;
			smps_low_power <= deep_sleep || chip_reset_reg;
			audio_low_power <= !audio_cells_enabled || chip_reset_reg;
		end
	end

	// Indicator pads; output enable high pulls the pad low and lights it
	logic [3:0] led_phase_reg;
	logic charger_led;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			led_phase_reg <= 4'h0;
		end else if (lf_tick_reg) begin
			led_phase_reg <= led_phase_reg == `PCR_LED_PERIOD_TICKS
				? 4'h0 : led_phase_reg + 4'h1;
		end
	end

	assign charger_led = chg_present && chg_state_reg != pcr_pkg::CHG_STANDBY
		&& (firmware_running || led_phase_reg == `PCR_LED_ON_TICK);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			indicator_pad_0_oe <= 1'b0;
			indicator_pad_1_oe <= 1'b0;
		end else begin
			indicator_pad_0_oe <= charger_led || fw_indicator_0;
			indicator_pad_1_oe <= fw_indicator_1;
		end
	end

	assign indicator_pad_0_out = 1'b0;
	assign indicator_pad_1_out = 1'b0;

	// Pin defaults while in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_force_input <= 1'b1;
			serial_rx_cts_pull_down <= 1'b1;
			serial_tx_rts_pull_up <= 1'b1;
			gpio_pull_down <= '1;
		end else begin
			pins_force_input <= chip_reset_reg;
			serial_rx_cts_pull_down <= 1'b1;
			serial_tx_rts_pull_up <= 1'b1;
			gpio_pull_down <= chip_reset_reg ? '1 : fw_gpio_pull_down;
		end
	end

	// Clock configuration
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			crystal_freq_sel <= XSEL_W'(`PCR_XTAL_SEL_MAX);
			osc_free_run <= 1'b1;
		end else begin
			if (chip_reset_reg) begin
				crystal_freq_sel <= XSEL_W'(`PCR_XTAL_SEL_MAX);
			end else if (fw_crystal_sel_write) begin
				crystal_freq_sel <= fw_crystal_sel;
			end
			osc_free_run <= !pin_sync[`PCR_IN_XTAL];
		end
	end

	// Data rate survives a warm reset only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_rate <= DRATE_W'(`PCR_DATA_RATE_COLD);
			ram_contents_valid <= 1'b0;
		end else if (chip_reset_reg && cold_reg) begin
			data_rate <= DRATE_W'(`PCR_DATA_RATE_COLD);
			ram_contents_valid <= 1'b0;
		end else begin
			if (fw_data_rate_write && !chip_reset_reg) begin
				data_rate <= fw_data_rate;
			end
			if (!chip_reset_reg) begin
				ram_contents_valid <= 1'b1;
			end
		end
	end

	// Status
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			high_side_enable_status <= 1'b0;
			charger_powered_status <= 1'b0;
		end else begin
			high_side_enable_status <= hi_pin;
			charger_powered_status <= chg_present;
		end
	end

	assign charge_state = chg_state_reg;
	assign chip_reset = chip_reset_reg;
	assign reset_was_cold = cold_reg;

endmodule

`default_nettype wire

// File: dv/pcr_power_control_asserts.sv
// Port-level checks for the power, charge and reset control block
`timescale 1ns/1ps
`default_nettype none

module pcr_power_control_asserts (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic fw_hv_enable,
	input wire logic hv_enable,
	input wire logic deep_sleep,
	input wire logic hv_low_power,
	input wire logic lv_low_power,
	input wire logic audio_cells_enabled,
	input wire logic audio_low_power,
	input wire logic charger_supply_input,
	input wire pcr_pkg::pcr_charge_state_type charge_state,
	input wire logic [15:0] charge_current_request,
	input wire logic [15:0] fast_charge_current_setting,
	input wire logic charge_cv_regulate,
	input wire logic uart_break_detected,
	input wire logic chip_reset,
	input wire logic [3:0] crystal_freq_sel,
	input wire logic indicator_pad_0_out,
	input wire logic fw_indicator_0,
	input wire logic indicator_pad_0_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence no_supply;
		!charger_supply_input [*8];
	endsequence
	sequence in_trickle;
		(charge_state == pcr_pkg::CHG_TRICKLE) [*3];
	endsequence
	sequence in_cc;
		(charge_state == pcr_pkg::CHG_FAST_CC) [*3];
	endsequence

	chk_fw_hv_on: assert property (fw_hv_enable && !chip_reset ##1 !chip_reset |-> hv_enable)
		else $error("hv regulator not enabled by firmware");
	chk_sleep_low_power: assert property (deep_sleep |=> hv_low_power && lv_low_power)
		else $error("linear regulators not in low power in sleep");
	chk_audio_idle_low: assert property (!audio_cells_enabled |=> audio_low_power)
		else $error("audio regulator not in low power");
	chk_supply_gone_off: assert property (no_supply |-> ##[0:16] charge_state == pcr_pkg::CHG_OFF)
		else $error("charger not off without supply");
	chk_trickle_current: assert property (in_trickle |-> charge_current_request == 16'h1194)
		else $error("trickle current request wrong");
	chk_cc_current: assert property (in_cc ##0 $stable(fast_charge_current_setting)
		|-> charge_current_request == fast_charge_current_setting)
		else $error("fast current request wrong");
	chk_cv_flag: assert property ((charge_state == pcr_pkg::CHG_FAST_CV) [*3] |-> charge_cv_regulate)
		else $error("constant voltage flag missing");
	chk_break_reset: assert property (uart_break_detected |-> ##[1:2] chip_reset)
		else $error("break did not reset");
	chk_crystal_default: assert property (chip_reset [*2] |-> crystal_freq_sel == 4'hf)
		else $error("crystal selection not maximum in reset");
	chk_pad_open_drain: assert property (indicator_pad_0_out == 1'b0)
		else $error("pad 0 driven high");
	chk_pad_fw_on: assert property (fw_indicator_0 |=> indicator_pad_0_oe)
		else $error("pad 0 not on by firmware");
endmodule

`default_nettype wire

// File: dv/pcr_battery_model.sv
// Battery cell seen through the charger comparators
`timescale 1ns/1ps
`default_nettype none

module pcr_battery_model #(
	parameter int FLOAT_MV = 4200
) (
	input wire logic [15:0] bat_mv,
	output logic below_trickle,
	output logic at_float,
	output logic below_recharge
);
	always_comb begin
		below_trickle = bat_mv < 16'd2900;
		at_float = bat_mv >= 16'(FLOAT_MV);
		below_recharge = bat_mv < 16'(FLOAT_MV - 150);
	end
endmodule

`default_nettype wire

// File: dv/tb_pcr_power_control.sv
// Self-checking bench for the power, charge and reset control block
`timescale 1ns/1ps
`default_nettype none

module tb_pcr_power_control;
	logic clk = 0, rst_n = 0, hi = 0, lo = 0, rpin_n = 1, sup = 0, done = 0, xtal = 1;
	logic por_lo = 0, por_hi = 1, brk = 0, wdog = 0, slp = 0, acell = 1, fwr = 0;
	logic lset = 0, lclr = 0, fhv = 0, flv = 0, fsm = 0, fau = 0, fi0 = 0, fi1 = 0;
	logic [15:0] cur = 16'h01f4, rate = 16'h0000, gpd = 16'h0000, bat_mv = 16'd2500;
	logic [3:0] xs = 4'h0;
	logic xw = 0, rw = 0, b_tr, b_fl, b_rc;
	logic hv, sm, lv, au, hvl, lvl, sml, aul, hs, cps, cv, p0o, p0e, p1o, p1e, crst, cold, pfi;
	logic rxp, txp, ofr, ramv;
	logic [15:0] creq, gpo, drate;
	logic [3:0] xsel;
	pcr_pkg::pcr_charge_state_type cst;
	int err_total = 0, compares = 0, n;

	always #10 clk = ~clk;

	pcr_battery_model i_pcr_battery_model (.bat_mv(bat_mv), .below_trickle(b_tr),
		.at_float(b_fl), .below_recharge(b_rc));

	pcr_power_control #(.LF_DIV(10)) i_pcr_power_control (.clk(clk), .rst_n(rst_n),
		.high_side_regulator_enable(hi), .low_side_regulator_enable(lo), .reset_pin_n(rpin_n),
		.charger_supply_input(sup), .bat_below_trickle(b_tr), .bat_at_float(b_fl),
		.bat_below_recharge(b_rc), .bat_charge_done(done), .crystal_input_present(xtal),
		.core_below_por_low(por_lo), .core_above_por_high(por_hi), .uart_break_detected(brk),
		.watchdog_expired(wdog), .deep_sleep(slp), .audio_cells_enabled(acell),
		.firmware_running(fwr), .fw_latch_set(lset), .fw_latch_clear(lclr), .fw_hv_enable(fhv),
		.fw_lv_enable(flv), .fw_smps_enable(fsm), .fw_audio_enable(fau), .fw_indicator_0(fi0),
		.fw_indicator_1(fi1), .fast_charge_current_setting(cur), .fw_crystal_sel(xs),
		.fw_crystal_sel_write(xw), .fw_data_rate(rate), .fw_data_rate_write(rw),
		.fw_gpio_pull_down(gpd), .hv_enable(hv), .smps_enable(sm), .lv_enable(lv),
		.audio_enable(au), .hv_low_power(hvl), .lv_low_power(lvl), .smps_low_power(sml),
		.audio_low_power(aul), .high_side_enable_status(hs), .charger_powered_status(cps),
		.charge_state(cst), .charge_current_request(creq), .charge_cv_regulate(cv),
		.indicator_pad_0_out(p0o), .indicator_pad_0_oe(p0e), .indicator_pad_1_out(p1o),
		.indicator_pad_1_oe(p1e), .chip_reset(crst), .reset_was_cold(cold),
		.pins_force_input(pfi), .serial_rx_cts_pull_down(rxp), .serial_tx_rts_pull_up(txp),
		.gpio_pull_down(gpo), .crystal_freq_sel(xsel), .osc_free_run(ofr), .data_rate(drate),
		.ram_contents_valid(ramv));

	task cyc(int c);
		repeat (c) @(negedge clk);
	endtask
	task chk_bit(logic e, logic g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task chk_vec(logic [15:0] e, logic [15:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wst(pcr_pkg::pcr_charge_state_type s);
		for (int i = 0; i < 60 && cst !== s; i++) cyc(1);
		chk_vec(16'(s), 16'(cst));
	endtask
	task automatic wrst(logic v);
		for (n = 0; n < 200 && crst !== v; n++) cyc(1);
		chk_bit(v, crst);
	endtask
	task print_verdict;
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#400000;
		err_total++;
		print_verdict;
	end

	initial begin
		cyc(10);
		chk_vec(16'h000f, 16'(xsel));
		chk_bit(1'b1, pfi);
		chk_vec(16'hffff, gpo);
		chk_bit(1'b1, hvl);
		chk_vec(16'h0000, drate);
		rst_n = 1;
		wrst(1'b0);
		gpd = 16'h00a5;
		cyc(3);
		chk_vec(16'h00a5, gpo);
		chk_bit(1'b1, rxp & txp);
		chk_vec(16'h0000, {13'h0, pfi, sml, ofr});
		chk_bit(1'b0, hv | lv | au);
		// Pins boot, firmware latches, pins released
		hi = 1;
		cyc(8);
		chk_vec(16'h000c, {12'h0, hv, sm, lv, au});
		chk_bit(1'b1, hs);
		lo = 1;
		cyc(8);
		chk_vec(16'h0003, {14'h0, lv, au});
		lset = 1;
		cyc(1);
		lset = 0;
		cyc(2);
		hi = 0;
		lo = 0;
		cyc(8);
		chk_vec(16'h000f, {12'h0, hv, sm, lv, au});
		lclr = 1;
		cyc(1);
		lclr = 0;
		cyc(3);
		chk_vec(16'h0000, {12'h0, hv, sm, lv, au});
		fau = 1;
		fhv = 1;
		flv = 1;
		cyc(2);
		chk_bit(1'b1, au);
		chk_vec(16'h000b, {12'h0, hv, sm, lv, au});
		fau = 0;
		fhv = 0;
		flv = 0;
		slp = 1;
		acell = 0;
		cyc(2);
		chk_vec(16'h0007, {13'h0, hvl, lvl, sml});
		chk_bit(1'b1, aul);
		slp = 0;
		acell = 1;
		cyc(2);
		chk_vec(16'h0000, {13'h0, hvl, lvl, aul});
		// Charger walk through every state
		sup = 1;
		wst(pcr_pkg::CHG_TRICKLE);
		cyc(2);
		chk_vec(16'h1194, creq);
		chk_bit(1'b1, cps);
		chk_vec(16'h0006, {13'h0, hv, lv, au});
		n = 0;
		repeat (200) begin
			cyc(1);
			n += int'(p0e);
		end
		chk_bit(1'b1, n >= 10 && n <= 20);
		fwr = 1;
		cyc(3);
		chk_bit(1'b1, p0e);
		bat_mv = 16'd3500;
		wst(pcr_pkg::CHG_FAST_CC);
		cyc(2);
		chk_vec(16'h01f4, creq);
		bat_mv = 16'd4200;
		wst(pcr_pkg::CHG_FAST_CV);
		cyc(2);
		chk_bit(1'b1, cv);
		done = 1;
		wst(pcr_pkg::CHG_STANDBY);
		done = 0;
		cyc(2);
		chk_vec(16'h0000, {15'h0, p0e});
		fi0 = 1;
		cyc(2);
		chk_bit(1'b1, p0e);
		fi0 = 0;
		bat_mv = 16'd4100;
		cyc(30);
		chk_vec(16'(pcr_pkg::CHG_STANDBY), 16'(cst));
		bat_mv = 16'd4000;
		wst(pcr_pkg::CHG_FAST_CC);
		fi1 = 1;
		cyc(2);
		chk_vec(16'h0002, {14'h0, p1e, p1o});
		sup = 0;
		wst(pcr_pkg::CHG_OFF);
		// Warm resets keep rate, reset crystal choice
		rate = 16'h1234;
		rw = 1;
		xs = 4'h3;
		xw = 1;
		cyc(1);
		rw = 0;
		xw = 0;
		cyc(2);
		chk_vec(16'h1234, drate);
		chk_vec(16'h0003, 16'(xsel));
		xtal = 0;
		cyc(6);
		chk_bit(1'b1, ofr);
		xtal = 1;
		brk = 1;
		cyc(1);
		brk = 0;
		wrst(1'b1);
		cyc(2);
		chk_vec(16'h000f, 16'(xsel));
		wrst(1'b0);
		chk_vec(16'h1234, drate);
		chk_bit(1'b0, cold);
		chk_bit(1'b1, ramv);
		wdog = 1;
		cyc(1);
		wdog = 0;
		wrst(1'b1);
		wrst(1'b0);
		rpin_n = 0;
		wrst(1'b1);
		chk_bit(1'b1, n >= 30 && n <= 86);
		cyc(110 - n);
		rpin_n = 1;
		wrst(1'b0);
		// Cold reset with supply hysteresis
		por_lo = 1;
		por_hi = 0;
		wrst(1'b1);
		cyc(4);
		chk_bit(1'b1, cold);
		chk_vec(16'h0000, drate);
		chk_bit(1'b0, ramv);
		por_lo = 0;
		cyc(20);
		chk_bit(1'b1, crst);
		por_hi = 1;
		wrst(1'b0);
		print_verdict;
	end
endmodule

bind pcr_power_control pcr_power_control_asserts i_pcr_power_control_asserts (.clk(clk),
	.rst_n(rst_n), .fw_hv_enable(fw_hv_enable), .hv_enable(hv_enable), .deep_sleep(deep_sleep),
	.hv_low_power(hv_low_power), .lv_low_power(lv_low_power),
	.audio_cells_enabled(audio_cells_enabled), .audio_low_power(audio_low_power),
	.charger_supply_input(charger_supply_input), .charge_state(charge_state),
	.charge_current_request(charge_current_request),
	.fast_charge_current_setting(fast_charge_current_setting),
	.charge_cv_regulate(charge_cv_regulate), .uart_break_detected(uart_break_detected),
	.chip_reset(chip_reset), .crystal_freq_sel(crystal_freq_sel),
	.indicator_pad_0_out(indicator_pad_0_out), .fw_indicator_0(fw_indicator_0),
	.indicator_pad_0_oe(indicator_pad_0_oe));

`default_nettype wire
